// >>> hw/tmz_pkg.sv
package tmz_pkg;
  localparam logic [7:0] COUNT_ADDR  = 8'h01;
  localparam logic [7:0] INTC_ADDR   = 8'h0B;
  localparam logic [7:0] OPT_ADDR    = 8'h81;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] INTC_RESET  = 8'h00;
  localparam logic [7:0] OPT_RESET   = 8'hFF;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  localparam int FLAG_BIT = 2;
  localparam int EN_BIT   = 5;
  localparam int CS_BIT   = 5;
  localparam int EDGE_BIT = 4;
  localparam int PSA_BIT  = 3;
  localparam int RATE_LSB = 0;
  localparam int RATE_W   = 3;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [1:0] PHASE_SECOND   = 2'h1;
  localparam logic [1:0] PHASE_FOURTH   = 2'h3;
endpackage

// >>> hw/tmz_timer.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tmz_timer (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  ext_count_input,
  input  wire logic                  sleep_mode,
  input  wire logic                  watchdog_clear_instr,
  input  wire logic                  wdt_tick,
  output logic                       wdt_postscaled,
  output logic                       irq
);
  import tmz_pkg::*;

  logic       rst_s1;
  logic       rst_n;
  logic       ext_s1;
  logic       ext_s2;
  logic       ext_lvl_d;
  logic [1:0] phase;
  logic [7:0] count_value;
  logic [7:0] option_config;
  logic       overflow_flag;
  logic       overflow_int_enable;
  logic [7:0] pre_cnt;
  logic [1:0] inhibit;
  logic       samp;

  // Reset released through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Decode
  wire wr_cnt  = reg_wr && (reg_addr == COUNT_ADDR);
  wire wr_intc = reg_wr && (reg_addr == INTC_ADDR);
  wire wr_opt  = reg_wr && (reg_addr == OPT_ADDR);

  wire             clock_source_select = option_config[CS_BIT];
  wire             count_edge_select   = option_config[EDGE_BIT];
  wire             prescaler_assign    = option_config[PSA_BIT];
  wire [RATE_W-1:0] prescale_rate      = option_config[RATE_LSB +: RATE_W];

  // Four clocks per instruction cycle, one per phase
  wire instr_tick  = (phase == PHASE_FOURTH);
  wire sample_now  = (phase == PHASE_SECOND) || (phase == PHASE_FOURTH);

  // Edge select inverts the pin so the chosen edge is always a rise
  wire ext_lvl  = ext_s2 ^ count_edge_select;
  wire ext_edge = ext_lvl && !ext_lvl_d;

  // Prescaler output: divided tap, or when not assigned the pin level in counter mode and zero in timer mode
  wire pre_out = !prescaler_assign ? pre_cnt[prescale_rate] :
                 (clock_source_select ? ext_lvl : 1'b0);
  wire samp_rise = sample_now && pre_out && !samp;

  // Only timer mode without prescaler bypasses the sampler
  wire direct_path = !clock_source_select && prescaler_assign;
  wire inc_src     = direct_path ? instr_tick : samp_rise;
  wire count_inc   = !sleep_mode && (inhibit == 2'h0) && inc_src && !wr_cnt;

  // Shared prescaler input and clears
  wire pre_in = prescaler_assign ? wdt_tick :
                (!sleep_mode && (clock_source_select ? ext_edge : instr_tick));
  wire pre_clr = (wr_cnt && !prescaler_assign) ||
                 (watchdog_clear_instr && prescaler_assign);
  wire [7:0] next_pre = pre_clr ? 8'h00 : 8'(pre_cnt + {7'h00, pre_in});

  // Watchdog postscaler fires every 2^rate ticks
  wire [7:0] post_mask   = 8'((8'h01 << prescale_rate) - 8'h01);
  wire       post_hit    = wdt_tick && ((pre_cnt & post_mask) == post_mask);
  wire       next_wdt    = prescaler_assign ? post_hit : wdt_tick;

  wire [7:0] next_count = wr_cnt ? reg_wdata :
                          8'(count_value + {7'h00, count_inc});
  wire [1:0] next_inhibit = wr_cnt ? INHIBIT_CYCLES :
                            ((instr_tick && inhibit != 2'h0) ? 2'(inhibit - 2'h1) : inhibit);

  // Set wins over a same-cycle write-one clear
  wire ovf_set   = count_inc && (count_value == COUNT_MAX);
  wire ovf_clr   = wr_intc && reg_wdata[FLAG_BIT];
  wire next_flag = ovf_set || (overflow_flag && !ovf_clr);
  wire next_en   = wr_intc ? reg_wdata[EN_BIT] : overflow_int_enable;

  wire [7:0] intc_view = (8'h01 << FLAG_BIT) & {8{overflow_flag}} |
                         (8'h01 << EN_BIT) & {8{overflow_int_enable}};
  wire [7:0] rd_mux = (reg_addr == COUNT_ADDR) ? count_value :
                      (reg_addr == INTC_ADDR)  ? intc_view :
                      (reg_addr == OPT_ADDR)   ? option_config : 8'h00;

  // Pin synchroniser; first flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1    <= 1'b0;
      ext_s2    <= 1'b0;
      // Idle low pin reads high under the reset edge select; avoids a false edge
      ext_lvl_d <= OPT_RESET[EDGE_BIT];
    end else begin
      ext_s1    <= ext_count_input;
      ext_s2    <= ext_s1;
      ext_lvl_d <= ext_lvl;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      samp  <= OPT_RESET[EDGE_BIT];
    end else begin
      phase <= 2'(phase + 2'h1);
      if (sample_now) begin
        samp <= pre_out;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= COUNT_RESET;
      inhibit     <= 2'h0;
      pre_cnt     <= 8'h00;
    end else begin
      count_value <= next_count;
      inhibit     <= next_inhibit;
      pre_cnt     <= next_pre;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      option_config       <= OPT_RESET;
      overflow_flag       <= INTC_RESET[FLAG_BIT];
      overflow_int_enable <= INTC_RESET[EN_BIT];
    end else begin
      if (wr_opt) begin
        option_config <= reg_wdata;
      end
      overflow_flag       <= next_flag;
      overflow_int_enable <= next_en;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata      <= 8'h00;
      irq            <= 1'b0;
      wdt_postscaled <= 1'b0;
    end else begin
      reg_rdata      <= reg_rd ? rd_mux : 8'h00;
      irq            <= next_flag && next_en;
      wdt_postscaled <= next_wdt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cnt_write;
    wr_cnt ##1 (!wr_cnt)[*5];
  endsequence

  sequence s_timer_step;
    direct_path && !sleep_mode && inhibit == 2'h0 && instr_tick && !wr_cnt;
  endsequence

  a_write_load: assert property (wr_cnt |=> count_value == $past(reg_wdata))
    else $error("count write not loaded");
  a_inhibit_two: assert property (s_cnt_write |-> count_value == $past(reg_wdata, 5))
    else $error("count moved within two instruction cycles of a write");
  a_timer_step: assert property (s_timer_step |=> count_value == 8'($past(count_value) + 8'h01))
    else $error("timer mode missed an instruction cycle");
  a_overflow_set: assert property (ovf_set |=> overflow_flag)
    else $error("overflow flag not set on wrap");
  a_irq_mask: assert property (irq |-> overflow_int_enable && overflow_flag)
    else $error("interrupt seen while masked or without flag");
  a_flag_sticky: assert property (overflow_flag && !ovf_clr |=> overflow_flag)
    else $error("overflow flag dropped without software clear");
  a_sleep_hold: assert property (sleep_mode && !wr_cnt |=> $stable(count_value))
    else $error("counter moved during sleep");
  a_sample_phase: assert property (clock_source_select && !wr_cnt && count_inc |-> sample_now)
    else $error("counter mode advanced off a sampling phase");
  a_presc_wrclr: assert property (wr_cnt && !prescaler_assign |=> pre_cnt == 8'h00)
    else $error("count write did not clear prescaler");
  a_presc_wdtclr: assert property (watchdog_clear_instr && prescaler_assign |=> pre_cnt == 8'h00)
    else $error("watchdog clear did not clear prescaler");

  // Cycles since the last count write, saturating; only the checks read it
  logic [3:0] since_wr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_wr <= 4'hF;
    end else if (wr_cnt) begin
      since_wr <= 4'h1;
    end else if (since_wr != 4'hF) begin
      since_wr <= 4'(since_wr + 4'h1);
    end
  end

  sequence s_pin_count;
    !direct_path && count_inc;
  endsequence

  // Register reads
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");

  a_rdata_count: assert property (
    reg_rd && reg_addr == COUNT_ADDR |=> reg_rdata == $past(count_value))
    else $error("count read returned wrong value");

  a_rdata_option: assert property (
    reg_rd && reg_addr == OPT_ADDR |=> reg_rdata == $past(option_config))
    else $error("option read returned wrong value");

  a_rdata_flag: assert property (
    reg_rd && reg_addr == INTC_ADDR |=> reg_rdata[FLAG_BIT] == $past(overflow_flag))
    else $error("control read shows wrong overflow flag");

  a_rdata_enable: assert property (
    reg_rd && reg_addr == INTC_ADDR |=> reg_rdata[EN_BIT] == $past(overflow_int_enable))
    else $error("control read shows wrong enable bit");

  a_rdata_unused: assert property (
    reg_rd && reg_addr == INTC_ADDR |=> (reg_rdata & 8'hDB) == 8'h00)
    else $error("unimplemented control bits read nonzero");

  a_rdata_unmapped: assert property (
    reg_rd && reg_addr != COUNT_ADDR && reg_addr != INTC_ADDR && reg_addr != OPT_ADDR
    |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero");

  // Control registers
  a_option_load: assert property (
    wr_opt |=> option_config == $past(reg_wdata))
    else $error("option write not stored");

  a_option_hold: assert property (
    !wr_opt |=> $stable(option_config))
    else $error("option changed without a write");

  a_enable_load: assert property (
    wr_intc |=> overflow_int_enable == $past(reg_wdata[EN_BIT]))
    else $error("enable write not stored");

  a_enable_hold: assert property (
    !wr_intc |=> $stable(overflow_int_enable))
    else $error("enable changed without a write");

  a_flag_clear: assert property (
    ovf_clr && !ovf_set |=> !overflow_flag)
    else $error("write one did not clear overflow flag");

  a_flag_cause: assert property (
    $rose(overflow_flag) |-> $past(ovf_set))
    else $error("overflow flag set without a wrap");

  a_flag_setwins: assert property (
    ovf_set && ovf_clr |=> overflow_flag)
    else $error("clear beat a same-cycle overflow");

  a_irq_follow: assert property (
    1'b1 |-> irq == (overflow_flag && overflow_int_enable))
    else $error("interrupt does not follow flag and enable");

  a_irq_masked: assert property (
    !overflow_int_enable |-> !irq)
    else $error("interrupt raised while masked");

  // Counter
  a_wrap_zero: assert property (
    ovf_set |=> count_value == 8'h00)
    else $error("count did not wrap to zero");

  a_count_hold: assert property (
    !count_inc && !wr_cnt |=> $stable(count_value))
    else $error("count moved without an increment");

  a_count_step: assert property (
    count_inc |=> count_value == 8'($past(count_value) + 8'h01))
    else $error("count increment not by one");

  a_inhibit_load: assert property (
    wr_cnt |=> inhibit == INHIBIT_CYCLES)
    else $error("count write did not start the inhibit");

  a_inhibit_block: assert property (
    inhibit != 2'h0 |-> !count_inc)
    else $error("increment during inhibit");

  a_inhibit_window: assert property (
    count_inc |-> since_wr >= 4'h6)
    else $error("increment too soon after a count write");

  a_sleep_noinc: assert property (
    sleep_mode |-> !count_inc)
    else $error("increment during sleep");

  a_sleep_noflag: assert property (
    sleep_mode |-> !ovf_set)
    else $error("overflow during sleep");

  a_timer_tick: assert property (
    direct_path && count_inc |-> instr_tick)
    else $error("timer mode advanced off an instruction cycle");

  // Pin sampler
  a_sample_only: assert property (
    s_pin_count |-> sample_now)
    else $error("sampled path advanced off a sampling phase");

  a_samp_hold: assert property (
    !sample_now |=> $stable(samp))
    else $error("sampler changed off a sampling phase");

  a_samp_take: assert property (
    sample_now |=> samp == $past(pre_out))
    else $error("sampler missed the prescaler output");

  a_edge_spacing: assert property (
    s_pin_count |=> (!count_inc || direct_path)[*3])
    else $error("sampled path counted twice within one cycle");

  a_phase_step: assert property (
    1'b1 |=> phase == 2'($past(phase) + 2'h1))
    else $error("phase counter skipped");

  a_pin_direct: assert property (
    clock_source_select && prescaler_assign && count_inc |-> ext_lvl)
    else $error("counter mode advanced without the pin level");

  // Shared prescaler
  a_pre_wdt_hold: assert property (
    prescaler_assign && !wdt_tick && !watchdog_clear_instr |=> $stable(pre_cnt))
    else $error("watchdog prescaler moved without a tick");

  a_pre_wdt_step: assert property (
    prescaler_assign && wdt_tick && !watchdog_clear_instr |=> pre_cnt == 8'($past(pre_cnt) + 8'h01))
    else $error("watchdog prescaler missed a tick");

  a_pre_sleep: assert property (
    !prescaler_assign && sleep_mode && !wr_cnt |=> $stable(pre_cnt))
    else $error("timer prescaler moved during sleep");

  a_pre_timer_step: assert property (
    !prescaler_assign && !clock_source_select && !sleep_mode && instr_tick && !wr_cnt
    |=> pre_cnt == 8'($past(pre_cnt) + 8'h01))
    else $error("timer prescaler missed an instruction cycle");

  a_tap_inc: assert property (
    !prescaler_assign && count_inc |-> pre_out)
    else $error("prescaled count without the tap high");

  a_wdt_direct: assert property (
    !prescaler_assign |=> wdt_postscaled == $past(wdt_tick))
    else $error("watchdog tick not passed straight through");

  a_wdt_cause: assert property (
    wdt_postscaled |-> $past(wdt_tick))
    else $error("postscaled pulse without a watchdog tick");

  a_wdt_rate_one: assert property (
    prescaler_assign && prescale_rate == 3'h0 && wdt_tick |=> wdt_postscaled)
    else $error("rate zero postscaler dropped a tick");
endmodule
`default_nettype wire

// >>> tb/tmz_ext_src.sv
`timescale 1ns/1ps
`default_nettype none
module tmz_ext_src (
  input  wire logic clk,
  input  wire logic go,
  output logic      pin,
  output logic      busy
);
  logic       level = 1'b0;
  logic [2:0] hold  = 3'h0;
  // One toggle per request; each level then stands 4 clks so both phase samples see it
  always_ff @(posedge clk) begin
    if (go)
      hold <= 3'h1;
    else if (hold != 3'h0)
      hold <= hold + 3'h1;
    if (hold == 3'h4)
      level <= ~level;
  end
  assign busy = (hold != 3'h0);
  assign pin  = level;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tmz_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       sleep_mode = 1'b0;
  logic       watchdog_clear_instr = 1'b0;
  logic       wdt_tick = 1'b0;
  logic       go = 1'b0;
  logic       pin, busy, post, irq;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, v, w;
  int         num_errors = 0;
  int         tests_run = 0;
  int         n_post = 0;
  int         p, n;
  always #10 clk = ~clk;
  always @(posedge clk) if (post === 1'b1) n_post <= n_post + 1;
  tmz_timer i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_input(pin), .sleep_mode(sleep_mode),
    .watchdog_clear_instr(watchdog_clear_instr), .wdt_tick(wdt_tick), .wdt_postscaled(post), .irq(irq));
  tmz_ext_src i_src (.clk(clk), .go(go), .pin(pin), .busy(busy));
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wd(input int k);
    repeat (k) begin
      wdt_tick <= 1'b1;
      @(posedge clk);
      wdt_tick <= 1'b0;
      cyc(1);
    end
  endtask
  task automatic clr_wd;
    watchdog_clear_instr <= 1'b1;
    @(posedge clk);
    watchdog_clear_instr <= 1'b0;
    cyc(1);
  endtask
  task automatic toggle_pin;
    int i;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (i = 0; i < 50 && busy; i++) cyc(1);
    if (busy !== 1'b0) begin
      num_errors++;
      finish_test();
    end
  endtask
  initial begin
    cyc(10);
    rstn <= 1'b1;
    cyc(4);
    rd(OPT_ADDR, v);
    chk(v, OPT_RESET);
    rd(INTC_ADDR, v);
    chk(v, INTC_RESET);
    rd(8'h02, v);
    chk(v, 8'h00);
    wr(OPT_ADDR, 8'h08);
    wr(COUNT_ADDR, 8'hF0);
    rd(COUNT_ADDR, v);
    chk(v, 8'hF0);
    cyc(39);
    rd(COUNT_ADDR, v);
    chk(v, 8'hF8);
    cyc(39);
    rd(COUNT_ADDR, w);
    chk(w, v + 8'h0A);
    chk({7'h00, irq}, 8'h00);
    rd(INTC_ADDR, v);
    chk(v, 8'h04);
    wr(INTC_ADDR, 8'h20);
    chk({7'h00, irq}, 8'h01);
    cyc(8);
    rd(INTC_ADDR, v);
    chk(v, 8'h24);
    wr(INTC_ADDR, 8'h24);
    chk({7'h00, irq}, 8'h00);
    wr(COUNT_ADDR, 8'hFF);
    sleep_mode <= 1'b1;
    cyc(40);
    rd(COUNT_ADDR, v);
    chk(v, 8'hFF);
    rd(INTC_ADDR, v);
    chk(v, 8'h20);
    sleep_mode <= 1'b0;
    clr_wd();
    for (n = 0; n < 8; n++) begin
      wr(OPT_ADDR, {5'h00, n[2:0]});
      wr(COUNT_ADDR, 8'h00);
      cyc(20);
      rd(COUNT_ADDR, v);
      cyc(1023);
      rd(COUNT_ADDR, w);
      chk(w - v, 8'h80 >> n);
    end
    clr_wd();
    wr(COUNT_ADDR, 8'h00);
    for (n = 0; n < 4; n++) begin
      wr(OPT_ADDR, (n < 2) ? 8'h28 : 8'h38);
      cyc(12);
      wr(COUNT_ADDR, 8'h40);
      cyc(12);
      toggle_pin();
      cyc(12);
      rd(COUNT_ADDR, v);
      chk(v, (n == 0 || n == 3) ? 8'h41 : 8'h40);
    end
    wr(OPT_ADDR, 8'h3A);
    clr_wd();
    p = n_post;
    wd(8);
    cyc(2);
    chk(8'(n_post - p), 8'h02);
    wd(3);
    clr_wd();
    wd(3);
    cyc(2);
    chk(8'(n_post - p), 8'h02);
    clr_wd();
    wr(OPT_ADDR, 8'h02);
    wd(3);
    cyc(2);
    chk(8'(n_post - p), 8'h05);
    finish_test();
  end
endmodule
`default_nettype wire
